/* File: logic/ism_input_sync_monitor.sv */
// input sync monitor: indicators, sample clock choice, latency paths, usb checks
`timescale 1ns/100ps
module ism_input_sync_monitor #(
    parameter int BLINK_HALF_CYCLES = ism_pkg::BLINK_HALF_CYCLES,
    parameter int INT_DIV = ism_pkg::INT_DIV
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // recovered input clocks and carrier detects, one bit per input
    input wire logic [ism_pkg::NUM_IN-1:0] in_clk_pin,
    input wire logic [ism_pkg::NUM_IN-1:0] in_carrier_pin,
    // clock mode
    input wire logic follow_input_clock_mode,
    input wire logic follow_sel,
    // digital pass-through audio
    input wire ism_pkg::ism_audio_s rx_audio,
    output ism_pkg::ism_audio_s tx_audio_ff,
    // playback audio and host buffer
    input wire ism_pkg::ism_audio_s play_in,
    input wire logic [15:0] host_buf_size,
    output ism_pkg::ism_audio_s play_out_ff,
    output logic [15:0] play_latency_ff,
    output logic [15:0] safety_offset_ff,
    // usb packet checks
    input wire ism_pkg::ism_usb_s usb_in,
    output logic [ism_pkg::CNT_W-1:0] usb_err_count_ff,
    output logic [ism_pkg::CNT_W-1:0] usb_pkt_count_ff,
    output logic [ism_pkg::POS_W-1:0] sample_pos_ff,
    // status
    output logic sample_tick_ff,
    output logic [ism_pkg::NUM_IN-1:0] led_ff,
    output logic [2*ism_pkg::NUM_IN-1:0] input_state_ff
);
    localparam int DIV_W = $clog2(INT_DIV + 1);
    localparam int BLK_W = $clog2(BLINK_HALF_CYCLES + 1);
    localparam int WIN_W = $clog2(ism_pkg::WINDOW_TICKS + 1);
    localparam int BUF_W = $clog2(ism_pkg::SAFETY_BUF_SAMPLES);

    logic [DIV_W-1:0] div_cnt_ff;
    logic [BLK_W-1:0] blink_cnt_ff;
    logic blink_ff;
    logic [WIN_W-1:0] win_cnt_ff;
    wire [ism_pkg::NUM_IN-1:0] edge_w;
    wire [ism_pkg::NUM_IN-1:0] nxt_led;
    wire [2*ism_pkg::NUM_IN-1:0] nxt_input_state;
    ism_pkg::ism_state_e state_w [ism_pkg::NUM_IN];
    ism_pkg::ism_audio_s pass_ff [ism_pkg::PASS_DELAY_SAMPLES];
    ism_pkg::ism_audio_s buf_mem [ism_pkg::SAFETY_BUF_SAMPLES];
    logic [BUF_W-1:0] buf_ptr_ff;
    logic [ism_pkg::SEQ_W-1:0] exp_seq_ff;

    // sample tick source
    wire int_tick = (div_cnt_ff == DIV_W'(INT_DIV - 1));
    wire ref_tick = follow_input_clock_mode ? edge_w[follow_sel] : int_tick;
    wire win_end = ref_tick && (win_cnt_ff == WIN_W'(ism_pkg::WINDOW_TICKS - 1));
    wire blink_wrap = (blink_cnt_ff == BLK_W'(BLINK_HALF_CYCLES - 1));

    // usb gap handling: missing packets still move the position on
    wire [ism_pkg::SEQ_W-1:0] gap = usb_in.seq - exp_seq_ff;
    wire [ism_pkg::POS_W-1:0] adv = (ism_pkg::POS_W'(gap) + ism_pkg::POS_W'(1))
                                    * ism_pkg::POS_W'(ism_pkg::SAMPLES_PER_PKT);
    wire usb_bad = usb_in.strobe && (usb_in.crc_err || gap != '0);

    genvar gi;
    generate
        for (gi = 0; gi < ism_pkg::NUM_IN; gi++)
        begin : g_in
            ism_clock_sync_checker u_chk (
                .sys_clk(sys_clk),
                .srst(srst),
                .clk_pin(in_clk_pin[gi]),
                .carrier_pin(in_carrier_pin[gi]),
                .win_end(win_end),
                .edge_ff(edge_w[gi]),
                .state_ff(state_w[gi])
            );
            assign nxt_led[gi] = (state_w[gi] == ism_pkg::ISM_SYNC) ||
                                 ((state_w[gi] == ism_pkg::ISM_LOCK) && blink_ff);
            assign nxt_input_state[2*gi +: 2] = state_w[gi];
            AST_SYNC_STEADY: assert property (@(posedge sys_clk) disable iff (srst)
                state_w[gi] == ism_pkg::ISM_SYNC |=> led_ff[gi])
                else $error("sync input indicator not steady");
            AST_LOCK_BLINKS: assert property (@(posedge sys_clk) disable iff (srst)
                state_w[gi] == ism_pkg::ISM_LOCK |=> led_ff[gi] == $past(blink_ff))
                else $error("locked input indicator not blinking");
            AST_NOLOCK_DARK: assert property (@(posedge sys_clk) disable iff (srst)
                state_w[gi] == ism_pkg::ISM_NO_LOCK |=> !led_ff[gi] ##1 1)
                else $error("unlocked input indicator lit");
        end
    endgenerate

    // one register for all inputs, so no output bit has two writers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            led_ff <= '0;
            input_state_ff <= '0;
        end
        else
        begin
            led_ff <= nxt_led;
            input_state_ff <= nxt_input_state;
        end
    end

    // dividers: internal rate, blink rate, measurement window
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            div_cnt_ff <= '0;
            blink_cnt_ff <= '0;
            blink_ff <= 1'b0;
            win_cnt_ff <= '0;
            sample_tick_ff <= 1'b0;
        end
        else
        begin
            div_cnt_ff <= int_tick ? '0 : div_cnt_ff + DIV_W'(1);
            blink_cnt_ff <= blink_wrap ? '0 : blink_cnt_ff + BLK_W'(1);
            blink_ff <= blink_wrap ? ~blink_ff : blink_ff;
            sample_tick_ff <= ref_tick;
            if (ref_tick)
                win_cnt_ff <= win_end ? '0 : win_cnt_ff + WIN_W'(1);
        end
    end

    // pass-through: four sample periods from receive to transmit
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < ism_pkg::PASS_DELAY_SAMPLES; i++)
                pass_ff[i] <= '0;
            tx_audio_ff <= '0;
        end
        else if (ref_tick)
        begin
            pass_ff[0] <= rx_audio;
            for (int i = 1; i < ism_pkg::PASS_DELAY_SAMPLES; i++)
                pass_ff[i] <= pass_ff[i-1];
            tx_audio_ff <= pass_ff[ism_pkg::PASS_DELAY_SAMPLES-1];
        end
    end

    // playback safety buffer; contents need no reset, only the pointer
    always_ff @(posedge sys_clk)
    begin
        if (ref_tick)
            buf_mem[buf_ptr_ff] <= play_in;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            buf_ptr_ff <= '0;
            play_out_ff <= '0;
            play_latency_ff <= '0;
            safety_offset_ff <= '0;
        end
        else
        begin
            if (ref_tick)
            begin
                play_out_ff <= buf_mem[buf_ptr_ff];
                buf_ptr_ff <= buf_ptr_ff + BUF_W'(1);
            end
            play_latency_ff <= host_buf_size + 16'(ism_pkg::SAFETY_BUF_SAMPLES);
            safety_offset_ff <= 16'(ism_pkg::SAFETY_OFFSET_SAMPLES);
        end
    end

    // usb checks and drop-out recovery
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            exp_seq_ff <= '0;
            usb_err_count_ff <= '0;
            usb_pkt_count_ff <= '0;
            sample_pos_ff <= '0;
        end
        else if (usb_in.strobe)
        begin
            exp_seq_ff <= usb_in.seq + ism_pkg::SEQ_W'(1);
            usb_pkt_count_ff <= usb_pkt_count_ff + ism_pkg::CNT_W'(1);
            if (usb_bad)
                usb_err_count_ff <= usb_err_count_ff + ism_pkg::CNT_W'(1);
            sample_pos_ff <= sample_pos_ff + adv;
        end
    end

    AST_FOLLOW_TICK: assert property (@(posedge sys_clk) disable iff (srst)
        follow_input_clock_mode && edge_w[follow_sel] |=> sample_tick_ff)
        else $error("follow mode tick missing");
    AST_MASTER_NO_FOLLOW: assert property (@(posedge sys_clk) disable iff (srst)
        !follow_input_clock_mode && !int_tick |=> !sample_tick_ff)
        else $error("master mode tick from wrong source");
    AST_PASS_DELAY: assert property (@(posedge sys_clk) disable iff (srst)
        ref_tick |=> tx_audio_ff == $past(pass_ff[ism_pkg::PASS_DELAY_SAMPLES-1]))
        else $error("pass-through delay wrong");
    AST_PLAY_LATENCY: assert property (@(posedge sys_clk) disable iff (srst)
        1'b1 |=> play_latency_ff ==
        16'($past(host_buf_size) + 16'(ism_pkg::SAFETY_BUF_SAMPLES)))
        else $error("playback latency missing safety buffer");
    AST_SAFETY_OFS: assert property (@(posedge sys_clk) disable iff (srst)
        $past(!srst) |-> safety_offset_ff == 16'(ism_pkg::SAFETY_OFFSET_SAMPLES))
        else $error("safety offset wrong");
    AST_ERR_COUNT: assert property (@(posedge sys_clk) disable iff (srst)
        usb_in.strobe && usb_in.crc_err |=>
        usb_err_count_ff == $past(usb_err_count_ff) + ism_pkg::CNT_W'(1))
        else $error("usb error not counted");
    AST_POS_GAP: assert property (@(posedge sys_clk) disable iff (srst)
        usb_in.strobe |=> sample_pos_ff == $past(sample_pos_ff) + $past(adv))
        else $error("sample position not corrected");
    AST_GAP_ERR: assert property (@(posedge sys_clk) disable iff (srst)
        usb_in.strobe && !usb_in.crc_err && usb_in.seq != exp_seq_ff |=>
        usb_err_count_ff == $past(usb_err_count_ff) + ism_pkg::CNT_W'(1))
        else $error("usb sequence gap not counted");
    AST_PKT_COUNT: assert property (@(posedge sys_clk) disable iff (srst)
        usb_in.strobe |=> usb_pkt_count_ff == $past(usb_pkt_count_ff) + ism_pkg::CNT_W'(1))
        else $error("usb packet not counted");
    AST_TX_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
        !ref_tick |=> $stable(tx_audio_ff))
        else $error("pass-through output changed between ticks");
endmodule

/* File: shared/ism_pkg.sv */
// constants and carriers for the input sync monitor
// How it works
// - a locked input that is not in step with the readout clock blinks its indicator.
// - a locked input that is also in step with the readout clock lights its indicator steadily.
// - the clock sync checker compares each input clock against the reference; the monitor blinks only the out-of-step locked ones.
// - each input reports no lock, lock or sync as a decoded two-bit state.
// - in follow input clock mode the sample tick comes from the chosen input instead of the internal divider.
// - the digital pass-through path delays each sample by exactly four sample periods.
// - playback samples pass a fixed extra buffer of thirty-two samples and the reported playback latency includes it.
// - a safety offset of sixteen samples is reported; nothing in the data path applies it.
// - USB transfer errors are detected and counted and the counts are presented.
// - lost USB packets do not stop the stream; the sample position is advanced over the gap at once.
package ism_pkg;
    localparam int NUM_IN = 2;
    localparam int IN_ADAT = 0;
    localparam int IN_SPDIF = 1;
    localparam int SAMPLE_W = 24;
    localparam int CNT_W = 16;
    localparam int SEQ_W = 8;
    localparam int POS_W = 32;
    localparam int WINDOW_TICKS = 256;
    localparam int LOCK_TOL = 4;
    localparam int PASS_DELAY_SAMPLES = 3;
    localparam int SAFETY_BUF_SAMPLES = 32;
    localparam int SAFETY_OFFSET_SAMPLES = 16;
    localparam int SAMPLES_PER_PKT = 8;
    localparam int INT_DIV = 8;
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int BLINK_HALF_MS = 125;
    localparam int BLINK_HALF_CYCLES = SYS_CLK_HZ / 1000 * BLINK_HALF_MS;

    typedef enum logic [1:0] {
        ISM_NO_LOCK = 2'h0,
        ISM_LOCK = 2'h1,
        ISM_SYNC = 2'h3
    } ism_state_e;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } ism_audio_s;

    typedef struct packed {
        logic strobe;
        logic crc_err;
        logic [SEQ_W-1:0] seq;
    } ism_usb_s;
endpackage

/* File: logic/ism_clock_sync_checker.sv */
// per-input clock sync checker: edge counting and lock/sync decision
`timescale 1ns/100ps
module ism_clock_sync_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // input pins
    input wire logic clk_pin,
    input wire logic carrier_pin,
    // measurement window end
    input wire logic win_end,
    // results
    output logic edge_ff,
    output ism_pkg::ism_state_e state_ff
);
    logic [2:0] clk_sync_ff;
    logic [1:0] car_sync_ff;
    logic [ism_pkg::CNT_W-1:0] edge_cnt_ff;
    ism_pkg::ism_state_e nxt_state;

    wire rise = clk_sync_ff[1] & ~clk_sync_ff[2];
    wire [ism_pkg::CNT_W-1:0] ref_cnt = ism_pkg::CNT_W'(ism_pkg::WINDOW_TICKS);
    wire [ism_pkg::CNT_W-1:0] diff = (edge_cnt_ff > ref_cnt) ? edge_cnt_ff - ref_cnt
                                                             : ref_cnt - edge_cnt_ff;
    wire exact = (edge_cnt_ff == ref_cnt);
    wire in_tol = (diff <= ism_pkg::CNT_W'(ism_pkg::LOCK_TOL));

    // exact match only counts as sync; small drift stays lock
    assign nxt_state = !car_sync_ff[1] ? ism_pkg::ISM_NO_LOCK :
                       exact ? ism_pkg::ISM_SYNC :
                       in_tol ? ism_pkg::ISM_LOCK : ism_pkg::ISM_NO_LOCK;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            clk_sync_ff <= 3'h0;
            car_sync_ff <= 2'h0;
            edge_cnt_ff <= '0;
            edge_ff <= 1'b0;
            state_ff <= ism_pkg::ISM_NO_LOCK;
        end
        else
        begin
            clk_sync_ff <= {clk_sync_ff[1:0], clk_pin};
            car_sync_ff <= {car_sync_ff[0], carrier_pin};
            edge_ff <= rise;
            if (win_end)
            begin
                edge_cnt_ff <= rise ? ism_pkg::CNT_W'(1) : '0;
                state_ff <= nxt_state;
            end
            else if (rise)
                edge_cnt_ff <= edge_cnt_ff + ism_pkg::CNT_W'(1);
        end
    end

    AST_SYNC_EXACT: assert property (@(posedge sys_clk) disable iff (srst)
        win_end && car_sync_ff[1] && exact |=> state_ff == ism_pkg::ISM_SYNC)
        else $error("exact count did not give sync");
    AST_LOCK_DRIFT: assert property (@(posedge sys_clk) disable iff (srst)
        win_end && car_sync_ff[1] && in_tol && !exact |=> state_ff == ism_pkg::ISM_LOCK)
        else $error("small drift lost lock");
endmodule

/* File: tb/ism_src_model.sv */
// digital audio source model: recovered clock and carrier of one input
`timescale 1ns/100ps
module ism_src_model #(
    parameter real HALF_NS = 200.0,
    parameter real START_NS = 137.0
) (
    // control from the bench
    input wire logic run,
    input wire logic carrier_on,
    // receiver pins
    output logic clk_pin,
    output logic carrier_pin
);
    assign carrier_pin = carrier_on;
    // a stopped source holds its level, as a dead link would
    initial
    begin
        clk_pin = 1'b0;
        #(START_NS);
        forever
        begin
            #(HALF_NS);
            clk_pin = run ? ~clk_pin : clk_pin;
        end
    end
endmodule

/* File: tb/ism_input_sync_monitor_test.sv */
// self-checking testbench for the input sync monitor
`timescale 1ns/100ps
module ism_input_sync_monitor_test;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] run = 2'h3;
    logic [1:0] car = 2'h3;
    wire [1:0] clk_pin;
    wire [1:0] car_pin;
    logic follow = 1'b0;
    logic fsel = 1'b0;
    ism_pkg::ism_audio_s rx = '0;
    ism_pkg::ism_audio_s play = '0;
    logic [15:0] hbuf = 16'h0;
    ism_pkg::ism_usb_s usb = '0;
    ism_pkg::ism_audio_s tx;
    ism_pkg::ism_audio_s pout;
    logic [15:0] lat;
    logic [15:0] soff;
    logic [15:0] errc;
    logic [15:0] pktc;
    logic [31:0] pos;
    logic tick;
    logic [1:0] led;
    logic [3:0] st;
    int mismatches = 0;
    int n_compared = 0;
    always #25 sys_clk = ~sys_clk;
    // spdif runs 1% slow: near enough to lock, never in sync
    ism_src_model #(.HALF_NS(200.0), .START_NS(137.0)) i_ism_src_model (.run(run[0]),
        .carrier_on(car[0]), .clk_pin(clk_pin[0]), .carrier_pin(car_pin[0]));
    ism_src_model #(.HALF_NS(202.0), .START_NS(61.0)) i_ism_src_model_b (.run(run[1]),
        .carrier_on(car[1]), .clk_pin(clk_pin[1]), .carrier_pin(car_pin[1]));
    ism_input_sync_monitor #(.BLINK_HALF_CYCLES(16), .INT_DIV(8)) i_ism_input_sync_monitor (
        .sys_clk(sys_clk), .srst(srst), .in_clk_pin(clk_pin), .in_carrier_pin(car_pin),
        .follow_input_clock_mode(follow), .follow_sel(fsel), .rx_audio(rx), .tx_audio_ff(tx),
        .play_in(play), .host_buf_size(hbuf), .play_out_ff(pout), .play_latency_ff(lat),
        .safety_offset_ff(soff), .usb_in(usb), .usb_err_count_ff(errc),
        .usb_pkt_count_ff(pktc), .sample_pos_ff(pos), .sample_tick_ff(tick), .led_ff(led),
        .input_state_ff(st));
    task automatic test_done();
        if (mismatches == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic wait_tick();
        int i;
        cyc(1);
        for (i = 0; i < 64 && tick !== 1'b1; i++)
            cyc(1);
        if (tick !== 1'b1)
        begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic t_sync();
        int i;
        int on0;
        int tog;
        logic prev;
        cyc(2048 * 3 + 20);
        chk(st, {ism_pkg::ISM_LOCK, ism_pkg::ISM_SYNC});
        on0 = 0;
        tog = 0;
        prev = led[1];
        for (i = 0; i < 40; i++)
        begin
            cyc(1);
            on0 += (led[0] === 1'b1);
            tog += (led[1] !== prev);
            prev = led[1];
        end
        chk(on0, 40);
        chk(tog >= 2, 1);
        car[1] = 1'b0;
        cyc(2048 + 20);
        chk(st, {ism_pkg::ISM_NO_LOCK, ism_pkg::ISM_SYNC});
        chk(led, 2'h1);
    endtask
    task automatic t_path();
        int n;
        hbuf = 16'h0040;
        cyc(2);
        chk(lat, 16'h0060);
        chk(soff, 16'h0010);
        hbuf = 16'hFFDF;
        cyc(2);
        chk(lat, 16'hFFFF);
        for (n = 0; n < 40; n++)
        begin
            wait_tick();
            if (n >= 4)
                chk(tx, {1'b1, 24'hA00000 + 24'(n - 4)});
            if (n >= 33)
                chk(pout, {1'b1, 24'h500000 + 24'(n - 33)});
            rx = {1'b1, 24'hA00000 + 24'(n)};
            play = {1'b1, 24'h500000 + 24'(n)};
        end
    endtask
    task automatic t_usb();
        logic [8:0] pk [5] = '{9'h000, 9'h001, 9'h003, 9'h104, 9'h005};
        logic [7:0] nxt;
        logic [7:0] gap;
        logic [15:0] e;
        logic [31:0] p;
        int i;
        nxt = 8'h00;
        e = 16'h0;
        p = 32'h0;
        // packets back to back: strobe stays up across all five
        for (i = 0; i < 5; i++)
        begin
            usb = {1'b1, pk[i][8], pk[i][7:0]};
            gap = pk[i][7:0] - nxt;
            e += 16'((pk[i][8] || gap != 8'h00) ? 1 : 0);
            p += 32'(gap) * 8 + 8;
            nxt = pk[i][7:0] + 8'h01;
            cyc(1);
            chk(pktc, 16'(i + 1));
            chk(errc, e);
            chk(pos, p);
        end
        usb = '0;
    endtask
    task automatic t_follow();
        int i;
        int n [4];
        follow = 1'b1;
        fsel = 1'b1;
        run[1] = 1'b0;
        // phases: stopped source, drifting source, steady source, internal divider
        for (int k = 0; k < 4; k++)
        begin
            cyc(20);
            n[k] = 0;
            for (i = 0; i < 64; i++)
            begin
                cyc(1);
                n[k] += (tick === 1'b1);
            end
            run[1] = 1'b1;
            follow = (k < 2);
            fsel = (k == 0);
        end
        chk(n[0], 0);
        chk(n[1] >= 7, 1);
        chk(n[2], 8);
        chk(n[3], 8);
    endtask
    initial
    begin
        cyc(8);
        srst = 1'b0;
        t_sync();
        t_path();
        t_usb();
        t_follow();
        test_done();
    end
endmodule
